/* logic/adsq_pkg.sv */
// adsq_pkg: constants, state encodings and carrier types of the converter sequencer
package adsq_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONV_CONTROL_0 = 8'h1F;
  localparam logic [7:0] IDX_ACQ_TIME_CONTROL = 8'h9B;
  localparam logic [7:0] IDX_CONV_CONTROL_1 = 8'h9F;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h1E;
  localparam logic [7:0] IDX_RESULT_LOW = 8'h9E;
  localparam logic [7:0] IDX_DONE_STATUS = 8'h0C;
  localparam logic [7:0] RST_CONV_CONTROL_0 = 8'h00;
  localparam logic [7:0] RST_CONV_CONTROL_1 = 8'h00;
  localparam logic [2:0] RST_ACQ_TIME_SEL = 3'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int C0_CLK_SEL_LSB = 6;
  localparam int C0_CHAN_LOW_LSB = 3;
  localparam int C0_GO = 2;
  localparam int C0_CHAN_HIGH = 1;
  localparam int C0_ON = 0;
  localparam int C1_FORMAT = 7;
  localparam int C1_HALVE = 6;
  localparam int C1_NEG_REF = 5;
  localparam int C1_POS_REF = 4;
  localparam int C2_ACQ_LSB = 3;
  localparam int ST_FLAG = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int INSTR_CYCLE_NS = 20;
  localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CONV_TADS = 4'hC;
  localparam logic [4:0] HOLDOFF_TADS = 5'h02;
  localparam logic [1:0] CLK_SEL_RC = 2'h3;
  localparam logic [9:0] FULL_SCALE = 10'h3FF;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_ACQ = 5'b00100,
    ST_CONV = 5'b01000,
    ST_HOLD = 5'b10000
  } adsq_state_t;

  // analog-side controls travel together
  typedef struct packed {
    logic [3:0] chan;
    logic sample;
    logic power;
    logic neg_ref_ext;
    logic pos_ref_ext;
    logic [13:0] analog_en;
    logic [9:0] trial;
  } adsq_analog_t;

  typedef struct packed {
    adsq_state_t state;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [2:0] acq;
    logic flag;
    logic [6:0] div_cnt;
    logic [4:0] tad_cnt;
    logic [3:0] step;
    logic [9:0] sar;
    logic [2:0] rc_s;
    logic rc_lvl;
    logic [2:0] cmp_s;
    logic cmp_lvl;
    logic wr_pend;
    logic rd_wait;
    logic [7:0] idx;
    logic idx_ok;
    logic [31:0] rdata;
  } adsq_state_s_t;

endpackage

/* logic/adsq_top.sv */
// adsq_top: sequencer for a 10-bit successive-approximation converter, AHB-Lite registers
`timescale 1ns/100ps

module adsq_top #(
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic i_clock, // system clock, 200 MHz
  input wire logic i_rst, // async reset, active high
  input wire logic i_hsel, // slave select
  input wire logic [31:0] i_haddr, // byte address
  input wire logic [1:0] i_htrans, // transfer type
  input wire logic i_hwrite, // write when high
  input wire logic [2:0] i_hsize, // transfer size
  input wire logic [31:0] i_hwdata, // write data
  input wire logic i_hready, // bus ready
  output logic [31:0] o_hrdata, // read data
  output logic o_hreadyout, // slave ready
  output logic o_hresp, // always okay
  input wire logic i_rc_clk, // free-running RC conversion clock
  input wire logic i_cmp, // comparator: held sample >= trial code
  output adsq_pkg::adsq_analog_t o_analog, // controls to the analog array
  output logic o_conv_done_flag // sticky done flag
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] tad_div(input logic [1:0] cs, input logic halve);
    tad_div = 7'h02 << (2 * int'(cs) + int'(halve));
  endfunction

  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0: acq_tads = 5'h00;
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0C;
      3'h6: acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

  adsq_pkg::adsq_state_s_t s, n;
  logic [9:0] result_q;
  logic [9:0] result_d;
  logic result_load;
  logic go_set;
  logic rc_sel;
  logic [6:0] div_lim;
  logic tad_tick;
  logic rc_rise;
  logic [3:0] chan;
  logic done_ev;
  logic [7:0] wd;
  logic [7:0] rd8;

  assign rc_sel = s.ctl0[adsq_pkg::C0_CLK_SEL_LSB +: 2] == adsq_pkg::CLK_SEL_RC;
  assign div_lim = tad_div(s.ctl0[adsq_pkg::C0_CLK_SEL_LSB +: 2], s.ctl1[adsq_pkg::C1_HALVE]);
  // rc edge counts only once the second and third stages agree
  assign rc_rise = (s.rc_s[1] == s.rc_s[2]) && s.rc_s[2] && !s.rc_lvl;
  assign tad_tick = rc_sel ? rc_rise : (s.div_cnt == div_lim - 7'h01);
  assign chan = {s.ctl0[adsq_pkg::C0_CHAN_HIGH], s.ctl0[adsq_pkg::C0_CHAN_LOW_LSB +: 3]};
  assign done_ev = (s.state == adsq_pkg::ST_CONV) && tad_tick
    && (s.step == adsq_pkg::CONV_TADS - 4'h1);
  assign wd = i_hwdata[7:0];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd8 = 8'h00;
    if (!s.idx_ok) begin
      rd8 = 8'h00;
    end else if (s.idx == adsq_pkg::IDX_CONV_CONTROL_0) begin
      rd8 = s.ctl0;
    end else if (s.idx == adsq_pkg::IDX_CONV_CONTROL_1) begin
      rd8 = s.ctl1;
    end else if (s.idx == adsq_pkg::IDX_ACQ_TIME_CONTROL) begin
      rd8 = {2'h0, s.acq, 3'h0};
    end else if (s.idx == adsq_pkg::IDX_RESULT_HIGH) begin
      rd8 = s.ctl1[adsq_pkg::C1_FORMAT] ? {6'h00, result_q[9:8]} : result_q[9:2];
    end else if (s.idx == adsq_pkg::IDX_RESULT_LOW) begin
      rd8 = s.ctl1[adsq_pkg::C1_FORMAT] ? result_q[7:0] : {result_q[1:0], 6'h00};
    end else if (s.idx == adsq_pkg::IDX_DONE_STATUS) begin
      rd8 = {7'h00, s.flag};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic go_clr;
    logic flag_clr;
    logic [3:0] bitn;
    n = s;
    go_set = 1'b0;
    go_clr = 1'b0;
    flag_clr = 1'b0;
    bitn = 4'h0;
    result_load = 1'b0;
    result_d = s.sar;

    // bus: address phase, then data phase
    n.wr_pend = 1'b0;
    n.rd_wait = 1'b0;
    if (s.rd_wait) begin
      n.rdata = {24'h000000, rd8};
    end
    if (i_hsel && i_htrans[1] && i_hready) begin
      n.idx = i_haddr[9:2];
      n.idx_ok = (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'h0);
      n.wr_pend = i_hwrite;
      n.rd_wait = !i_hwrite;
    end
    if (s.wr_pend && s.idx_ok) begin
      if (s.idx == adsq_pkg::IDX_CONV_CONTROL_0) begin
        n.ctl0 = {wd[7:3], s.ctl0[adsq_pkg::C0_GO], wd[1:0]};
        go_set = wd[adsq_pkg::C0_GO] && wd[adsq_pkg::C0_ON];
      end else if (s.idx == adsq_pkg::IDX_CONV_CONTROL_1) begin
        n.ctl1 = wd;
      end else if (s.idx == adsq_pkg::IDX_ACQ_TIME_CONTROL) begin
        n.acq = wd[adsq_pkg::C2_ACQ_LSB +: 3];
      end else if (s.idx == adsq_pkg::IDX_DONE_STATUS) begin
        flag_clr = !wd[adsq_pkg::ST_FLAG];
      end
    end

    // synchronisers
    n.rc_s = {s.rc_s[1:0], i_rc_clk};
    if (s.rc_s[1] == s.rc_s[2]) begin
      n.rc_lvl = s.rc_s[2];
    end
    // comparator settles four clocks after a trial change:
    // bit periods under five clocks convert wrong
    n.cmp_s = {s.cmp_s[1:0], i_cmp};
    if (s.cmp_s[1] == s.cmp_s[2]) begin
      n.cmp_lvl = s.cmp_s[2];
    end

    // bit-period divider runs only while a sequence is active
    if (s.state == adsq_pkg::ST_IDLE || s.state == adsq_pkg::ST_DELAY || tad_tick) begin
      n.div_cnt = 7'h00;
    end else begin
      n.div_cnt = s.div_cnt + 7'h01;
    end

    case (s.state)
      adsq_pkg::ST_IDLE: begin
        n.step = 4'h0;
        if (s.ctl0[adsq_pkg::C0_GO]) begin
          if (s.acq != 3'h0) begin
            n.state = adsq_pkg::ST_ACQ;
            n.tad_cnt = acq_tads(s.acq);
          end else if (rc_sel) begin
            n.state = adsq_pkg::ST_DELAY;
            n.tad_cnt = 5'(adsq_pkg::INSTR_CYCLE_CLKS - 1);
          end else begin
            n.state = adsq_pkg::ST_CONV;
          end
        end
      end
      adsq_pkg::ST_DELAY: begin
        n.tad_cnt = s.tad_cnt - 5'h01;
        if (s.tad_cnt == 5'h00) begin
          n.state = adsq_pkg::ST_CONV;
        end
      end
      adsq_pkg::ST_ACQ: begin
        if (tad_tick) begin
          n.tad_cnt = s.tad_cnt - 5'h01;
          if (s.tad_cnt == 5'h01) begin
            n.state = adsq_pkg::ST_CONV;
          end
        end
      end
      adsq_pkg::ST_CONV: begin
        if (tad_tick) begin
          n.step = s.step + 4'h1;
          bitn = 4'hA - s.step;
          if (s.step == 4'h0) begin
            n.sar = 10'h200; // first period holds the sample
          end else if (s.step <= 4'hA) begin
            n.sar[bitn] = s.cmp_lvl;
            if (bitn != 4'h0) begin
              n.sar[bitn - 4'h1] = 1'b1;
            end
          end
          if (done_ev) begin
            go_clr = 1'b1;
            result_load = 1'b1;
            n.state = adsq_pkg::ST_HOLD;
            n.tad_cnt = adsq_pkg::HOLDOFF_TADS;
          end
        end
      end
      adsq_pkg::ST_HOLD: begin
        if (tad_tick) begin
          n.tad_cnt = s.tad_cnt - 5'h01;
          if (s.tad_cnt == 5'h01) begin
            n.state = adsq_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        n.state = adsq_pkg::ST_IDLE;
      end
    endcase

    if (SMALL_PKG && chan >= 4'h5 && chan <= 4'h7) begin
      result_d = adsq_pkg::FULL_SCALE;
    end

    // converter off: abort without flag
    if (!s.ctl0[adsq_pkg::C0_ON]) begin
      n.state = adsq_pkg::ST_IDLE;
      go_clr = 1'b1;
      result_load = 1'b0;
    end

    // a new start beats the clear, a completion beats software's clear
    n.ctl0[adsq_pkg::C0_GO] = (s.ctl0[adsq_pkg::C0_GO] && !go_clr) || go_set;
    n.flag = (s.flag && !flag_clr) || (result_load);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.state <= adsq_pkg::ST_IDLE;
      s.ctl0 <= adsq_pkg::RST_CONV_CONTROL_0;
      s.ctl1 <= adsq_pkg::RST_CONV_CONTROL_1;
      s.acq <= adsq_pkg::RST_ACQ_TIME_SEL;
    end else begin
      s <= n;
    end
  end

  // no reset: contents stay unknown until the first completion
  always_ff @(posedge i_clock) begin
    if (result_load) begin
      result_q <= result_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    o_analog.chan = chan;
    o_analog.power = s.ctl0[adsq_pkg::C0_ON];
    // sampling switch opens for conversion and the hold-off
    o_analog.sample = s.ctl0[adsq_pkg::C0_ON] && (s.state == adsq_pkg::ST_IDLE
      || s.state == adsq_pkg::ST_DELAY || s.state == adsq_pkg::ST_ACQ);
    o_analog.neg_ref_ext = s.ctl1[adsq_pkg::C1_NEG_REF];
    o_analog.pos_ref_ext = s.ctl1[adsq_pkg::C1_POS_REF];
    for (int i = 0; i < 14; i++) begin
      o_analog.analog_en[i] = (s.ctl1[3:0] < 4'h2) || (i + int'(s.ctl1[3:0]) < 15);
    end
    o_analog.trial = s.sar;
  end

  assign o_hrdata = s.rdata;
  assign o_hreadyout = !s.rd_wait;
  assign o_hresp = 1'b0;
  assign o_conv_done_flag = s.flag;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  a_done_clears_go: assert property (done_ev && s.ctl0[adsq_pkg::C0_ON] && !go_set
    |=> !s.ctl0[adsq_pkg::C0_GO] && s.flag)
    else $error("completion did not clear go or set flag");
  a_result_load: assert property (result_load |=> result_q == $past(result_d))
    else $error("result not loaded on completion");
  a_conv_start: assert property ($rose(s.state == adsq_pkg::ST_CONV)
    |-> s.step == 4'h0)
    else $error("conversion did not start at step zero");
  a_conv_twelve: assert property ($rose(s.state == adsq_pkg::ST_HOLD)
    |-> s.step == 4'hC)
    else $error("conversion did not take twelve bit periods");
  a_holdoff_two: assert property (done_ev && s.ctl0[adsq_pkg::C0_ON]
    |=> s.state == adsq_pkg::ST_HOLD && s.tad_cnt == 5'h02)
    else $error("hold-off not two bit periods");
  a_off_aborts: assert property (!s.ctl0[adsq_pkg::C0_ON] && !go_set
    |=> s.state == adsq_pkg::ST_IDLE && !s.ctl0[adsq_pkg::C0_GO] && !$rose(s.flag))
    else $error("converter off did not abort cleanly");
  a_no_sample_conv: assert property (s.state == adsq_pkg::ST_CONV
    || s.state == adsq_pkg::ST_HOLD |-> !o_analog.sample)
    else $error("sampling during conversion");
  a_go_busy: assert property (s.state == adsq_pkg::ST_DELAY
    || s.state == adsq_pkg::ST_ACQ || s.state == adsq_pkg::ST_CONV
    |-> s.ctl0[adsq_pkg::C0_GO])
    else $error("go low while a conversion is active");
  a_resume_sample: assert property ($fell(s.state == adsq_pkg::ST_HOLD)
    && s.ctl0[adsq_pkg::C0_ON] |-> o_analog.sample)
    else $error("sampling did not resume after hold-off");
  a_rc_delay: assert property ($rose(s.state == adsq_pkg::ST_DELAY)
    |-> $past(rc_sel) && $past(s.acq) == 3'h0 ##4 s.state == adsq_pkg::ST_CONV)
    else $error("rc start delay wrong");
  a_acq_first: assert property ($rose(s.state == adsq_pkg::ST_ACQ)
    |-> s.tad_cnt == acq_tads(s.acq) && o_analog.sample)
    else $error("acquisition not loaded");
  a_acq_reg_zero: assert property ($past(s.rd_wait)
    && s.idx == adsq_pkg::IDX_ACQ_TIME_CONTROL
    |-> o_hrdata[7:6] == 2'h0 && o_hrdata[2:0] == 3'h0)
    else $error("unimplemented bits not zero");
  a_right_just: assert property ($past(s.rd_wait) && s.idx == adsq_pkg::IDX_RESULT_HIGH
    && s.idx_ok && s.ctl1[adsq_pkg::C1_FORMAT] |-> o_hrdata[7:2] == 6'h00)
    else $error("right justified high bits not zero");

endmodule

/* dv/adsq_array_model.sv */
// adsq_array_model: behavioural sample-and-hold, comparator and rc clock source
`timescale 1ns/100ps

module adsq_array_model (
  input wire logic i_clock, // system clock
  input wire adsq_pkg::adsq_analog_t i_analog, // controls from the sequencer
  input wire logic [9:0] i_level, // level on the selected input
  output logic o_cmp, // held sample >= trial
  output logic o_rc_clk // free-running rc clock
);
  logic [9:0] held;
  logic tog;

  // ----------------------------------------------------------------
  // hold capacitor tracks only while sampling
  // ----------------------------------------------------------------
  initial begin
    tog = 1'b0;
    o_rc_clk = 1'b0;
    forever #48.5 o_rc_clk = ~o_rc_clk;
  end

  always @(posedge i_clock) begin
    tog <= ~tog;
    if (i_analog.sample) begin
      held <= i_level;
    end
  end

  // unpowered comparator gives nothing useful, so it toggles
  assign o_cmp = i_analog.power ? (held >= i_analog.trial) : tog;
endmodule

/* dv/adsq_top_tb_top.sv */
// adsq_top_tb_top: self-checking bench of the converter sequencer
`timescale 1ns/100ps

module adsq_top_tb_top;
  logic i_clock, i_rst, i_hwrite, o_hreadyout, o_hresp, rc_clk, cmp, o_conv_done_flag;
  logic [1:0] i_htrans;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd_v, hi, lo;
  logic [9:0] level, r;
  adsq_pkg::adsq_analog_t o_analog;
  int mismatches, samples_checked, c, t, s, e;
  logic [7:0] v;
  logic [2:0] a;
  logic [1:0] cs;
  logic h, fmt;

  // small-package build, so channels 5 to 7 must convert to full scale
  adsq_top #(.SMALL_PKG(1'b1)) u_adsq_top (.i_clock(i_clock), .i_rst(i_rst), .i_hsel(1'b1),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_rc_clk(rc_clk), .i_cmp(cmp), .o_analog(o_analog),
    .o_conv_done_flag(o_conv_done_flag));
  adsq_array_model u_adsq_array_model (.i_clock(i_clock), .i_analog(o_analog),
    .i_level(level), .o_cmp(cmp), .o_rc_clk(rc_clk));

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // checks, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chk_rng(input string n, input int lo_b, input int hi_b, input int g);
    samples_checked++;
    if (g < lo_b || g > hi_b) begin
      mismatches++;
      $display("unexpected %s expected %0d..%0d seen %0d", n, lo_b, hi_b, g);
    end
  endtask

  task automatic wt;
    int n;
    n = 0;
    @(posedge i_clock);
    while (o_hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk("hready", 1, 0);
        results();
      end
      @(posedge i_clock);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    i_htrans <= 2'h2;
    i_haddr <= {22'h0, idx, 2'h0};
    i_hwrite <= w;
    wt();
    i_htrans <= 2'h0;
    i_hwdata <= {24'h0, d};
    wt();
    rd_v = o_hrdata;
  endtask

  task automatic wait_on(input logic want, input int lim, output int n);
    n = 0;
    while ((want ? o_conv_done_flag : o_analog.sample) !== 1'b1) begin
      @(posedge i_clock);
      n++;
      if (n > lim) begin
        chk("wait", 1, 0);
        results();
      end
    end
  endtask

  function automatic int tper(input logic hv, input logic [1:0] code);
    return (code == 2'h0 ? 2 : code == 2'h1 ? 8 : 32) << hv;
  endfunction

  function automatic int acqn(input logic [2:0] code);
    int tbl[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    return tbl[code];
  endfunction

  // unimplemented upper inputs go digital first
  function automatic logic [13:0] en_exp(input int k);
    return k < 2 ? 14'h3FFF : 14'h3FFF >> (k - 1);
  endfunction

  function automatic logic [31:0] just(input logic f, input logic [9:0] r);
    return f ? {16'h0, 6'h0, r[9:8], r[7:0]} : {16'h0, r[9:2], r[1:0], 6'h0};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    i_htrans = 2'h0;
    i_haddr = 32'h0;
    i_hwrite = 1'b0;
    i_hwdata = 32'h0;
    level = 10'h0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'hA23B));
    repeat (12) @(posedge i_clock);
    chk("power", 0, o_analog.power);
    chk("analog_en", 14'h3FFF, o_analog.analog_en);
    i_rst <= 1'b0;
    @(posedge i_clock);
    xfer(0, 8'h1F, 0); chk("ctl0", 0, rd_v);
    xfer(0, 8'h9F, 0); chk("ctl1", 0, rd_v);
    xfer(0, 8'h9B, 0); chk("acq", 0, rd_v);
    xfer(0, 8'h55, 0); chk("unmapped", 0, rd_v);
    chk("hresp", 0, o_hresp);
    xfer(1, 8'h9B, 8'hFF);
    xfer(0, 8'h9B, 0); chk("acq", 32'h38, rd_v);
    $display("test registers done");
    for (int k = 0; k < 16; k++) begin
      v = {4'($urandom()), 4'(k)};
      xfer(1, 8'h9F, v);
      xfer(0, 8'h9F, 0); chk("ctl1", v, rd_v);
      chk("analog_en", en_exp(k), o_analog.analog_en);
      chk("neg_ref", v[5], o_analog.neg_ref_ext);
      chk("pos_ref", v[4], o_analog.pos_ref_ext);
    end
    for (int k = 0; k < 16; k++) begin
      xfer(1, 8'h1F, {2'h0, 3'(k), 1'b0, k[3], 1'b1});
      // the write lands on the edge the task returns at
      @(posedge i_clock);
      chk("chan", k, o_analog.chan);
      chk("power", 1, o_analog.power);
    end
    $display("test config done");
    for (int i = 0; i < 14; i++) begin
      h = i % 2;
      cs = 2'((i / 2) % 4);
      a = (i == 6) ? 3'h0 : (i < 8 ? 3'(i) : 3'($urandom()));
      fmt = 1'($urandom());
      level = 10'($urandom());
      t = tper(h, cs);
      xfer(1, 8'h9B, {2'h0, a, 3'h0});
      xfer(1, 8'h9F, {fmt, h, 6'h0});
      xfer(1, 8'h1F, {cs, 3'(i), 1'b1, 1'(i / 8), 1'b1});
      xfer(0, 8'h1F, 0); chk("go", 1, rd_v[2]);
      wait_on(1, 9000, c);
      e = (acqn(a) + 12) * t;
      if (cs != 2'h3) begin
        chk_rng("conv time", e - t, e + 9, c + 3);
      end
      chk("sample", 0, o_analog.sample);
      wait_on(0, 400, s);
      if (cs != 2'h3) chk_rng("holdoff", 2 * t - 1, 2 * t + 8, s);
      xfer(0, 8'h1F, 0); chk("go", 0, rd_v[2]);
      xfer(0, 8'h1E, 0); hi = rd_v;
      xfer(0, 8'h9E, 0); lo = rd_v;
      r = (i >= 5 && i <= 7) ? 10'h3FF : level;
      // comparator crosses three flops: bit periods under five clocks cannot settle
      if (t >= 8 || cs == 2'h3) begin
        chk("result", just(fmt, r), (hi << 8) | lo);
      end
      xfer(0, 8'h0C, 0); chk("done", 1, rd_v);
      xfer(1, 8'h0C, 8'h00);
      xfer(0, 8'h0C, 0); chk("done", 0, rd_v);
    end
    $display("test conversions done");
    xfer(1, 8'h9B, 8'h00);
    xfer(1, 8'h9F, 8'hC0);
    xfer(1, 8'h1F, 8'h85);
    repeat (100) @(posedge i_clock);
    xfer(1, 8'h1F, 8'h00);
    xfer(0, 8'h1F, 0); chk("go", 0, rd_v);
    xfer(0, 8'h0C, 0); chk("done", 0, rd_v);
    chk("power", 0, o_analog.power);
    xfer(1, 8'h1F, 8'h85);
    repeat (50) @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    xfer(0, 8'h1F, 0); chk("ctl0", 0, rd_v);
    chk("sample", 0, o_analog.sample);
    chk("flag pin", 0, o_conv_done_flag);
    $display("test abort done");
    results();
  end
endmodule
